// File: shared/atr_pkg.sv
package atr_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PRE_W  = 10;
    localparam int NUM_BUF = 5;
    localparam int NUM_IRQ = 3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } atr_bus_req_t;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTL_A = 8'hb0;
    localparam logic [ADDR_W-1:0] OFS_CTL_B = 8'hb1;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'hb2;
    localparam logic [ADDR_W-1:0] OFS_CMP_A = 8'hb3;
    localparam logic [ADDR_W-1:0] OFS_CMP_B = 8'hb4;
    localparam logic [ADDR_W-1:0] OFS_ASYNC = 8'hb6;
    localparam logic [ADDR_W-1:0] OFS_MASK  = 8'h70;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h37;

    // async status fields; busy bits double as buffer entry index
    localparam int ASR_EXTERNAL_CLOCK_ENABLE   = 6;
    localparam int ASR_ASEL    = 5;
    localparam int BUSY_COUNT  = 4;
    localparam int BUSY_CMP_A  = 3;
    localparam int BUSY_CMP_B  = 2;
    localparam int BUSY_CTL_A  = 1;
    localparam int BUSY_CTL_B  = 0;

    // flag and mask bits
    localparam int FLG_MATCH_B = 2;
    localparam int FLG_MATCH_A = 1;
    localparam int FLG_OVF     = 0;

    // control fields
    localparam logic [DATA_W-1:0] CTL_A_WMASK = 8'hf3;
    localparam logic [DATA_W-1:0] CTL_B_WMASK = 8'h0f;
    localparam logic [DATA_W-1:0] FULL_WMASK  = 8'hff;
    localparam int COM_A_LSB = 6;
    localparam int COM_B_LSB = 4;
    localparam int WGM_LSB   = 0;
    localparam int WGM2_BIT  = 3;
    localparam int CS_LSB    = 0;

    localparam logic [DATA_W-1:0] RST_VAL = 8'h00;
    localparam logic [DATA_W-1:0] CNT_MAX = 8'hff;
    localparam logic [DATA_W-1:0] CNT_BOT = 8'h00;
    localparam logic [DATA_W-1:0] CNT_ONE = 8'h01;

    typedef enum logic [2:0] {
        CS_STOP    = 3'b000,
        CS_DIV1    = 3'b001,
        CS_DIV8    = 3'b010,
        CS_DIV32   = 3'b011,
        CS_DIV64   = 3'b100,
        CS_DIV128  = 3'b101,
        CS_DIV256  = 3'b110,
        CS_DIV1024 = 3'b111
    } atr_clk_sel_t;

    typedef enum logic [1:0] {
        WGM_NORMAL = 2'b00,
        WGM_PC     = 2'b01,
        WGM_CTC    = 2'b10,
        WGM_FAST   = 2'b11
    } atr_wgm_t;

    localparam logic [1:0] COM_OFF    = 2'b00;
    localparam logic [1:0] COM_TOGGLE = 2'b01;
    localparam logic [1:0] COM_CLEAR  = 2'b10;
    localparam logic [1:0] COM_SET    = 2'b11;

    // prescaler tap masks: tick when the low bits are all ones
    localparam logic [PRE_W-1:0] PRE_M8    = 10'h007;
    localparam logic [PRE_W-1:0] PRE_M32   = 10'h01f;
    localparam logic [PRE_W-1:0] PRE_M64   = 10'h03f;
    localparam logic [PRE_W-1:0] PRE_M128  = 10'h07f;
    localparam logic [PRE_W-1:0] PRE_M256  = 10'h0ff;
    localparam logic [PRE_W-1:0] PRE_M1024 = 10'h3ff;
    localparam logic [PRE_W-1:0] PRE_ZERO  = 10'h000;
    localparam logic [PRE_W-1:0] PRE_ONE   = 10'h001;

endpackage

// File: core/atr_core.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - clock select zero stops the counter; 001 counts every source tick.
// - clock select 010..111 divide the source by 8,32,64,128,256,1024.
// - software reads and writes the 8-bit counter directly.
// - a counter write blocks the compare match on the next timer tick.
// - both compare registers are compared continuously; match drives flag.
// - external clock bit with async picks pin buffer, else crystal runs.
// - async select zero counts on io clock, one on the oscillator pin.
// - changing async select may corrupt timer registers; software rewrites.
// - async writes park in shadow storage and raise busy bits 4..0.
// - counter reads return live value; compare and control reads return shadow storage.
// - mask bits 2,1,0 gate flags into irq; irq_req is also gated by the global interrupt bit.
// - a counter match with a compare register sets its match flag.
// - executing an interrupt vector clears the matching flag.
// - writing one to a flag clears it; zero leaves it.
// - overflow flag sets at max, at top in fast pwm with compare-a top, or on turning at zero in phase correct.
module atr_core (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire atr_pkg::atr_bus_req_t bus_req,
    output logic [atr_pkg::DATA_W-1:0] bus_rdata,
    input  wire logic                  timer_osc_pin_one,
    input  wire logic                  global_irq_en,
    input  wire logic [atr_pkg::NUM_IRQ-1:0] vector_ack,
    output logic [atr_pkg::NUM_IRQ-1:0] irq_req,
    output logic                       irq,
    output logic                       wave_out_a,
    output logic                       wave_out_b,
    output logic                       osc_run,
    output logic                       ext_clk_buf_en
);

    localparam int DW = atr_pkg::DATA_W;
    localparam int NB = atr_pkg::NUM_BUF;
    localparam int NI = atr_pkg::NUM_IRQ;

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic          external_clock_enable;
    logic          async_select;
    logic [NB-1:0] busy;
    logic [DW-1:0] shadow [NB];
    logic [DW-1:0] live   [NB];
    logic [DW-1:0] count;
    logic          count_down;
    logic          block_match;
    logic [NI-1:0] flags;
    logic [NI-1:0] mask;
    logic [atr_pkg::PRE_W-1:0] presc;

    logic          osc_meta;
    logic          osc_sync;
    logic          osc_prev;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    wire logic wr = bus_req.wr;
    wire logic rd = bus_req.rd;
    wire logic [DW-1:0] wdata = bus_req.wdata;
    wire logic [atr_pkg::ADDR_W-1:0] addr = bus_req.addr;

    wire logic [NB-1:0] wr_hit = {
        wr && addr == atr_pkg::OFS_COUNT,
        wr && addr == atr_pkg::OFS_CMP_A,
        wr && addr == atr_pkg::OFS_CMP_B,
        wr && addr == atr_pkg::OFS_CTL_A,
        wr && addr == atr_pkg::OFS_CTL_B
    };
    wire logic wr_async = wr && addr == atr_pkg::OFS_ASYNC;
    wire logic wr_mask  = wr && addr == atr_pkg::OFS_MASK;
    wire logic wr_flags = wr && addr == atr_pkg::OFS_FLAGS;

    wire logic [DW-1:0] wmask [NB] = '{
        atr_pkg::CTL_B_WMASK,
        atr_pkg::CTL_A_WMASK,
        atr_pkg::FULL_WMASK,
        atr_pkg::FULL_WMASK,
        atr_pkg::FULL_WMASK
    };

    ////////////////////////////////////////////////////////////////////////
    // timer source clock and prescaler

    // the pin is sampled, so it must toggle well below half of clk
    wire logic osc_rise   = osc_sync && !osc_prev;
    wire logic src_tick   = async_select ? osc_rise : 1'b1;
    wire logic commit     = async_select && osc_rise;
    wire logic asel_flip  = wr_async &&
                            wdata[atr_pkg::ASR_ASEL] != async_select;

    wire logic [DW-1:0] ctl_a = live[atr_pkg::BUSY_CTL_A];
    wire logic [DW-1:0] ctl_b = live[atr_pkg::BUSY_CTL_B];
    wire logic [DW-1:0] cmp_a = live[atr_pkg::BUSY_CMP_A];
    wire logic [DW-1:0] cmp_b = live[atr_pkg::BUSY_CMP_B];

    wire atr_pkg::atr_clk_sel_t clk_sel =
        atr_pkg::atr_clk_sel_t'(ctl_b[atr_pkg::CS_LSB +: 3]);

    function automatic logic [atr_pkg::PRE_W-1:0] tap_mask(
        input atr_pkg::atr_clk_sel_t sel
    );
        unique case (sel)
            atr_pkg::CS_STOP:    tap_mask = atr_pkg::PRE_ZERO;
            atr_pkg::CS_DIV1:    tap_mask = atr_pkg::PRE_ZERO;
            atr_pkg::CS_DIV8:    tap_mask = atr_pkg::PRE_M8;
            atr_pkg::CS_DIV32:   tap_mask = atr_pkg::PRE_M32;
            atr_pkg::CS_DIV64:   tap_mask = atr_pkg::PRE_M64;
            atr_pkg::CS_DIV128:  tap_mask = atr_pkg::PRE_M128;
            atr_pkg::CS_DIV256:  tap_mask = atr_pkg::PRE_M256;
            atr_pkg::CS_DIV1024: tap_mask = atr_pkg::PRE_M1024;
        endcase
    endfunction

    wire logic [atr_pkg::PRE_W-1:0] tap = tap_mask(clk_sel);
    wire logic pre_hit    = (presc & tap) == tap;
    wire logic timer_tick = src_tick && pre_hit &&
                            clk_sel != atr_pkg::CS_STOP;

    ////////////////////////////////////////////////////////////////////////
    // counting sequence

    wire atr_pkg::atr_wgm_t wgm =
        atr_pkg::atr_wgm_t'(ctl_a[atr_pkg::WGM_LSB +: 2]);
    wire logic wgm2    = ctl_b[atr_pkg::WGM2_BIT];
    wire logic mode_pc = wgm == atr_pkg::WGM_PC;
    wire logic use_ocra_top = wgm == atr_pkg::WGM_CTC || wgm2;
    wire logic [DW-1:0] top = use_ocra_top ? cmp_a : atr_pkg::CNT_MAX;
    wire logic at_top  = count == top;
    wire logic at_bot  = count == atr_pkg::CNT_BOT;
    wire logic at_max  = count == atr_pkg::CNT_MAX;

    wire logic turn_down = mode_pc && !count_down && at_top;
    wire logic turn_up   = mode_pc && count_down && at_bot;
    wire logic go_down   = mode_pc && (turn_down || (count_down && !at_bot));

    wire logic [DW-1:0] next_count_run =
        go_down ? count - atr_pkg::CNT_ONE :
        (!mode_pc && at_top) ? atr_pkg::CNT_BOT :
        count + atr_pkg::CNT_ONE;

    // fast pwm with compare-a top flags at top; phase correct flags on turning at bottom; others flag at max
    wire logic ovf_point = mode_pc ? turn_up :
                           (wgm == atr_pkg::WGM_FAST && wgm2) ? at_top :
                           at_max;

    wire logic load_direct = wr_hit[atr_pkg::BUSY_COUNT] && !async_select;
    wire logic load_commit = commit && busy[atr_pkg::BUSY_COUNT];
    wire logic count_load  = load_direct || load_commit;
    wire logic [DW-1:0] load_val =
        load_direct ? wdata : shadow[atr_pkg::BUSY_COUNT];

    ////////////////////////////////////////////////////////////////////////
    // match and flag events

    wire logic match_a = timer_tick && !block_match && count == cmp_a;
    wire logic match_b = timer_tick && !block_match && count == cmp_b;
    wire logic ovf_evt = timer_tick && ovf_point;

    wire logic [NI-1:0] set_evt = {match_b, match_a, ovf_evt};
    wire logic [NI-1:0] sw_clr  = wr_flags ? wdata[NI-1:0] : '0;
    // set beats both clears so a same-cycle event is never dropped
    wire logic [NI-1:0] next_flags =
        (flags & ~sw_clr & ~vector_ack) | set_evt;
    wire logic [NI-1:0] next_irq_req =
        next_flags & mask & {NI{global_irq_en}};

    wire logic [1:0] com_a = ctl_a[atr_pkg::COM_A_LSB +: 2];
    wire logic [1:0] com_b = ctl_a[atr_pkg::COM_B_LSB +: 2];

    function automatic logic wave_next(
        input logic       cur,
        input logic       hit,
        input logic [1:0] com
    );
        wave_next = cur;
        if (hit) begin
            unique case (com)
                atr_pkg::COM_OFF:    wave_next = cur;
                atr_pkg::COM_TOGGLE: wave_next = !cur;
                atr_pkg::COM_CLEAR:  wave_next = 1'b0;
                atr_pkg::COM_SET:    wave_next = 1'b1;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // read mux

    wire logic [DW-1:0] async_rd =
        {1'b0, external_clock_enable, async_select, busy[NB-1:0]};
    wire logic [DW-1:0] rd_mux =
        addr == atr_pkg::OFS_COUNT ? count :
        addr == atr_pkg::OFS_CMP_A ? shadow[atr_pkg::BUSY_CMP_A] :
        addr == atr_pkg::OFS_CMP_B ? shadow[atr_pkg::BUSY_CMP_B] :
        addr == atr_pkg::OFS_CTL_A ? shadow[atr_pkg::BUSY_CTL_A] :
        addr == atr_pkg::OFS_CTL_B ? shadow[atr_pkg::BUSY_CTL_B] :
        addr == atr_pkg::OFS_ASYNC ? async_rd :
        addr == atr_pkg::OFS_MASK  ? {{(DW-NI){1'b0}}, mask} :
        addr == atr_pkg::OFS_FLAGS ? {{(DW-NI){1'b0}}, flags} :
        atr_pkg::RST_VAL;

    ////////////////////////////////////////////////////////////////////////
    // buffered registers: shadow, busy and live copy per entry

    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : gen_buf
            // a new write during busy is software's fault and not guarded
            wire logic set_busy = wr_hit[g] && async_select;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    shadow[g] <= atr_pkg::RST_VAL;
                    busy[g]   <= 1'b0;
                end else begin
                    if (wr_hit[g]) begin
                        shadow[g] <= wdata & wmask[g];
                    end
                    // pending transfers are dropped when the source flips
                    busy[g] <= set_busy ||
                               (busy[g] && !commit && !asel_flip);
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    live[g] <= atr_pkg::RST_VAL;
                end else if (wr_hit[g] && !async_select) begin
                    live[g] <= wdata & wmask[g];
                end else if (commit && busy[g]) begin
                    live[g] <= shadow[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // clock source, prescaler and counter

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= timer_osc_pin_one;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            external_clock_enable        <= 1'b0;
            async_select <= 1'b0;
        end else if (wr_async) begin
            external_clock_enable        <= wdata[atr_pkg::ASR_EXTERNAL_CLOCK_ENABLE];
            async_select <= wdata[atr_pkg::ASR_ASEL];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc <= atr_pkg::PRE_ZERO;
        end else if (asel_flip) begin
            presc <= atr_pkg::PRE_ZERO;
        end else if (src_tick) begin
            presc <= presc + atr_pkg::PRE_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count      <= atr_pkg::RST_VAL;
            count_down <= 1'b0;
        end else if (count_load) begin
            count      <= load_val;
        end else if (timer_tick) begin
            count      <= next_count_run;
            count_down <= go_down && !turn_up;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            block_match <= 1'b0;
        end else if (count_load) begin
            block_match <= 1'b1;
        end else if (timer_tick) begin
            block_match <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags, mask and outputs

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
            mask  <= '0;
        end else begin
            flags <= next_flags;
            if (wr_mask) begin
                mask <= wdata[NI-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req        <= '0;
            irq            <= 1'b0;
            bus_rdata      <= atr_pkg::RST_VAL;
            wave_out_a     <= 1'b0;
            wave_out_b     <= 1'b0;
            osc_run        <= 1'b0;
            ext_clk_buf_en <= 1'b0;
        end else begin
            irq_req        <= next_irq_req;
            irq            <= |(next_flags & mask);
            bus_rdata      <= rd ? rd_mux : atr_pkg::RST_VAL;
            wave_out_a     <= wave_next(wave_out_a, match_a, com_a);
            wave_out_b     <= wave_next(wave_out_b, match_b, com_b);
            osc_run        <= async_select && !external_clock_enable;
            ext_clk_buf_en <= async_select && external_clock_enable;
        end
    end

endmodule

// File: verif/atr_core_checker.sv
`timescale 1ns/1ps
module atr_core_checker (
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire atr_pkg::atr_bus_req_t       bus_req,
    input wire logic [atr_pkg::DATA_W-1:0]  bus_rdata,
    input wire logic                        timer_osc_pin_one,
    input wire logic                        global_irq_en,
    input wire logic [atr_pkg::NUM_IRQ-1:0] vector_ack,
    input wire logic [atr_pkg::NUM_IRQ-1:0] irq_req,
    input wire logic                        irq,
    input wire logic                        wave_out_a,
    input wire logic                        wave_out_b,
    input wire logic                        osc_run,
    input wire logic                        ext_clk_buf_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    sequence rd_of(a);
        $past(bus_req.rd) && $past(bus_req.addr) == a;
    endsequence
    sequence async_wr(sel);
        bus_req.wr && bus_req.addr == atr_pkg::OFS_ASYNC
            && bus_req.wdata[6:5] == sel;
    endsequence
    sequence mask_off;
        bus_req.wr && bus_req.addr == atr_pkg::OFS_MASK
            && bus_req.wdata[2:0] == 3'b000;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    AST_RDATA_IDLE: assert property (
        !$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    AST_ASYNC_TOP: assert property (
        rd_of(atr_pkg::OFS_ASYNC) |-> bus_rdata[7] == 1'b0)
        else $error("async status bit 7 reads one");
    AST_MASK_HI: assert property (
        rd_of(atr_pkg::OFS_MASK) |-> bus_rdata[7:3] == 5'h00)
        else $error("mask upper bits read nonzero");
    AST_FLAG_HI: assert property (
        rd_of(atr_pkg::OFS_FLAGS) |-> bus_rdata[7:3] == 5'h00)
        else $error("flag upper bits read nonzero");
    AST_OSC_EXCL: assert property (
        !(osc_run && ext_clk_buf_en))
        else $error("crystal and pin buffer both on");
    AST_OSC_SEL: assert property (
        async_wr(2'b01) |-> ##[1:2] (osc_run && !ext_clk_buf_en))
        else $error("crystal not started in async mode");
    AST_EXT_SEL: assert property (
        async_wr(2'b11) |-> ##[1:2] (ext_clk_buf_en && !osc_run))
        else $error("pin buffer not enabled");
    AST_SYNC_SEL: assert property (
        bus_req.wr && bus_req.addr == atr_pkg::OFS_ASYNC && !bus_req.wdata[5]
        |-> ##[1:2] !(osc_run || ext_clk_buf_en))
        else $error("oscillator left on in sync mode");
    AST_IRQ_GLOBAL: assert property (
        !$past(global_irq_en) |-> irq_req == 3'b000)
        else $error("request without global enable");
    AST_REQ_IRQ: assert property (
        irq_req != 3'b000 |-> irq)
        else $error("request without irq level");
    AST_IRQ_MASKED: assert property (
        mask_off ##1 !(bus_req.wr && bus_req.addr == atr_pkg::OFS_MASK)
        |=> !irq)
        else $error("irq high with all sources masked");
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} atr_row_t;
    localparam atr_row_t ROWS [0:10] = '{
        '{atr_pkg::OFS_CTL_A, 8'hff, 8'hf3}, '{atr_pkg::OFS_CTL_A, 8'h00, 8'h00},
        '{atr_pkg::OFS_CTL_B, 8'hf0, 8'h00}, '{atr_pkg::OFS_COUNT, 8'ha5, 8'ha5},
        '{atr_pkg::OFS_CMP_A, 8'h5a, 8'h5a}, '{atr_pkg::OFS_CMP_B, 8'hc3, 8'hc3},
        '{atr_pkg::OFS_MASK, 8'hff, 8'h07}, '{atr_pkg::OFS_MASK, 8'h00, 8'h00},
        '{atr_pkg::OFS_ASYNC, 8'h9f, 8'h00}, '{atr_pkg::OFS_FLAGS, 8'hff, 8'h00},
        '{8'h00, 8'h55, 8'h00}};
    localparam int DIVS [1:7] = '{1, 8, 32, 64, 128, 256, 1024};
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    atr_pkg::atr_bus_req_t req = '0;
    logic [7:0]            bus_rdata;
    logic                  pin = 1'b0;
    logic                  gie = 1'b0;
    logic [2:0]            vack = 3'b000;
    logic [2:0]            irq_req;
    logic                  irq, wave_a, wave_b, osc_run, ext_en;
    int                    n_fail = 0;
    int                    check_count = 0;
    int                    cycles = 0;

    always #10 clk = ~clk;

    atr_core dut_u (.clk(clk), .rst_n(rst_n), .bus_req(req),
        .bus_rdata(bus_rdata), .timer_osc_pin_one(pin), .global_irq_en(gie),
        .vector_ack(vack), .irq_req(irq_req), .irq(irq),
        .wave_out_a(wave_a), .wave_out_b(wave_b), .osc_run(osc_run),
        .ext_clk_buf_en(ext_en));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk8(bus_rdata, e);
    endtask
    // window between the two control writes is exactly n source cycles
    task automatic run(input logic [7:0] cs, input int n);
        bus_wr(atr_pkg::OFS_CTL_B, cs);
        repeat (n - 2) @(posedge clk);
        bus_wr(atr_pkg::OFS_CTL_B, 8'h00);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        foreach (ROWS[i]) begin
            bus_wr(ROWS[i].a, ROWS[i].d);
            rd_chk(ROWS[i].a, ROWS[i].e);
        end
        do_reset();
        foreach (ROWS[i]) rd_chk(ROWS[i].a, 8'h00);
        for (int k = 1; k <= 7; k++) begin
            bus_wr(atr_pkg::OFS_COUNT, 8'h00);
            run(k[7:0], 4 * DIVS[k]);
            rd_chk(atr_pkg::OFS_COUNT, 8'h04);
        end
        repeat (20) @(posedge clk);
        rd_chk(atr_pkg::OFS_COUNT, 8'h04);
        // first tick at 0xfe is blocked by the count write
        bus_wr(atr_pkg::OFS_CMP_A, 8'hff);
        bus_wr(atr_pkg::OFS_CMP_B, 8'h00);
        bus_wr(atr_pkg::OFS_FLAGS, 8'h07);
        bus_wr(atr_pkg::OFS_MASK, 8'h01);
        gie <= 1'b1;
        bus_wr(atr_pkg::OFS_COUNT, 8'hfe);
        run(8'h01, 3);
        rd_chk(atr_pkg::OFS_COUNT, 8'h01);
        rd_chk(atr_pkg::OFS_FLAGS, 8'h07);
        settle();
        chk8({5'h00, irq_req}, 8'h01);
        chk1(irq, 1'b1);
        gie <= 1'b0;
        settle();
        chk8({5'h00, irq_req}, 8'h00);
        bus_wr(atr_pkg::OFS_FLAGS, 8'h00);
        rd_chk(atr_pkg::OFS_FLAGS, 8'h07);
        bus_wr(atr_pkg::OFS_FLAGS, 8'h01);
        rd_chk(atr_pkg::OFS_FLAGS, 8'h06);
        settle();
        chk1(irq, 1'b0);
        for (int k = 1; k <= 2; k++) begin
            @(posedge clk);
            vack <= 3'(3'b001 << k);
            @(posedge clk);
            vack <= 3'b000;
            rd_chk(atr_pkg::OFS_FLAGS, (k == 1) ? 8'h04 : 8'h00);
        end
        // both compare outputs toggle on their match
        bus_wr(atr_pkg::OFS_CTL_A, 8'h50);
        bus_wr(atr_pkg::OFS_CMP_A, 8'h12);
        bus_wr(atr_pkg::OFS_COUNT, 8'h10);
        run(8'h01, 4);
        rd_chk(atr_pkg::OFS_FLAGS, 8'h02);
        chk1(wave_a, 1'b1);
        chk1(wave_b, 1'b0);
        for (int k = 0; k <= 1; k++) begin
            bus_wr(atr_pkg::OFS_FLAGS, 8'h07);
            bus_wr(atr_pkg::OFS_CMP_B, 8'h20 + k[7:0]);
            bus_wr(atr_pkg::OFS_COUNT, 8'h20);
            run(8'h01, 2);
            rd_chk(atr_pkg::OFS_FLAGS, (k == 1) ? 8'h04 : 8'h00);
        end
        chk1(wave_b, 1'b1);
        // external clock enable goes in before async mode is selected
        bus_wr(atr_pkg::OFS_ASYNC, 8'h40);
        bus_wr(atr_pkg::OFS_ASYNC, 8'h60);
        settle();
        chk1(ext_en, 1'b1);
        chk1(osc_run, 1'b0);
        // compare a and the counter are each written once, while not busy
        bus_wr(atr_pkg::OFS_CMP_A, 8'h77);
        bus_wr(atr_pkg::OFS_COUNT, 8'h33);
        rd_chk(atr_pkg::OFS_ASYNC, 8'h78);
        rd_chk(atr_pkg::OFS_CMP_A, 8'h77);
        rd_chk(atr_pkg::OFS_COUNT, 8'h22);
        pin <= 1'b1;
        repeat (6) @(posedge clk);
        pin <= 1'b0;
        repeat (6) @(posedge clk);
        rd_chk(atr_pkg::OFS_ASYNC, 8'h60);
        rd_chk(atr_pkg::OFS_COUNT, 8'h33);
        bus_wr(atr_pkg::OFS_ASYNC, 8'h20);
        settle();
        chk1(osc_run, 1'b1);
        chk1(ext_en, 1'b0);
        bus_wr(atr_pkg::OFS_ASYNC, 8'h00);
        settle();
        chk1(osc_run, 1'b0);
        complete_run();
    end
endmodule

bind atr_core atr_core_checker chk_u (.clk(clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata),
    .timer_osc_pin_one(timer_osc_pin_one), .global_irq_en(global_irq_en),
    .vector_ack(vector_ack), .irq_req(irq_req), .irq(irq),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .osc_run(osc_run),
    .ext_clk_buf_en(ext_clk_buf_en));
